// >>> core/sync_action_regs.vh
`ifndef SYNC_ACTION_REGS_VH
`define SYNC_ACTION_REGS_VH
// Activation factor codes
`define FAC_NOP 4'h0
`define FAC_RISE 4'hA
`define FAC_FALL 4'hB
`define FAC_LO_RISE 4'hC
`define FAC_HI_RISE 4'hD
`define FAC_LO_FALL 4'hE
`define FAC_HI_FALL 4'hF
// Action codes
`define ACT_NOP 5'h00
`define ACT_LD_SPEED 5'h01
`define ACT_LD_PCNT 5'h02
`define ACT_LD_SPLIT 5'h03
`define ACT_LD_SET 5'h04
`define ACT_SV_LPOS 5'h05
`define ACT_SV_RPOS 5'h06
`define ACT_SV_TIMER 5'h07
`define ACT_SV_CUR 5'h08
`define ACT_PULSE 5'h09
`define ACT_REL 5'h0A
`define ACT_CREL 5'h0B
`define ACT_ABS 5'h0C
`define ACT_CONT_P 5'h0D
`define ACT_CONT_N 5'h0E
`define ACT_MR_REL 5'h0F
`define ACT_MR_ABS 5'h10
`define ACT_DEC_STOP 5'h11
`define ACT_INST_STOP 5'h12
`define ACT_SPD_UP 5'h13
`define ACT_SPD_DN 5'h14
`define ACT_TMR_START 5'h15
`define ACT_TMR_STOP 5'h16
`define ACT_SPLIT_START 5'h17
`define ACT_SPLIT_STOP 5'h18
// Pulse width on general I/O, ns
`define PULSE_WIDTH_NS 1000
`define CLK_PERIOD_NS 50
`define PULSE_CYCLES ((`PULSE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> core/pin_trigger_detect.v
`timescale 1ns/1ps
`default_nettype none
`include "sync_action_regs.vh"
module pin_trigger_detect (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Set control
    input wire enable,
    input wire [3:0] factor,
    // Synchronised pins
    input wire edge_pin,
    input wire qual_pin,
    // Result
    output wire fire
);
    reg prev_r;
    reg armed_r;
    wire rise = ~prev_r & edge_pin;
    wire fall = prev_r & ~edge_pin;
    reg hit;
    always @* begin
        case (factor)
            `FAC_RISE: hit = rise;
            `FAC_FALL: hit = fall;
            `FAC_LO_RISE: hit = rise & ~qual_pin;
            `FAC_HI_RISE: hit = rise & qual_pin;
            `FAC_LO_FALL: hit = fall & ~qual_pin;
            `FAC_HI_FALL: hit = fall & qual_pin;
            default: hit = 1'b0;
        endcase
    end
    // Edge history runs while disabled and the first enabled cycle is masked, so a pin already at its post-edge level waits
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev_r <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            prev_r <= edge_pin;
            armed_r <= enable;
        end
    end
    assign fire = enable & armed_r & hit;
endmodule
`default_nettype wire

// >>> core/sync_action_trigger_dispatch.v
// Notes on behaviour
// - Low qualifier with rising edge pin triggers the set.
// - High qualifier with rising edge pin triggers the set.
// - Low qualifier with falling edge pin triggers the set.
// - High qualifier with falling edge pin triggers the set.
// - Low qualifier, edge pin high at enable: wait for fresh rise.
// - High qualifier, edge pin high at enable: wait for fresh rise.
// - Low qualifier, edge pin low at enable: wait for fresh fall.
// - High qualifier, edge pin low at enable: wait for fresh fall.
// - Set k uses pin k as edge and pin k+4 as qualifier.
// - Codes 01-03 load speed, pulse count, split data; 04 per-set load.
// - Codes 05-07 save positions or timer; 08 saves speed on set 0, ramp on set 1, nothing on sets 2 and 3.
// - Codes 0A-0C start relative, counter-relative, absolute driving.
// - Codes 0D, 0E start continuous driving plus and minus.
// - Code 17 starts split pulse at the activation.
// - Code 18 ends running split pulse at the activation.
// - Plain edge factor never fires at enable on post-edge level.
// - Codes 0F, 10 load pulse count from register and start driving in the same cycle.
// - Codes 11, 12 stop by deceleration or instantly.
// - Codes 13, 14 step speed; ignored in S-curve ramp or interpolation.
`timescale 1ns/1ps
`default_nettype none
`include "sync_action_regs.vh"
module sync_action_trigger_dispatch #(
    parameter DW = 32,
    parameter PULSE_CYC = `PULSE_CYCLES
) (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Per-set setup, four sets packed low to high
    input wire [3:0] set_enable,
    input wire [15:0] set_factor,
    input wire [19:0] set_action,
    input wire [3:0] pulse_neg_logic,
    // General I/O pins
    input wire [7:0] general_io_pin_in,
    output reg [3:0] general_io_pin_out,
    output reg [3:0] general_io_pin_oe,
    // Multi-purpose registers, four sets packed low to high
    input wire [4*DW-1:0] multi_purpose_compare_register,
    output reg [4*DW-1:0] mpr_save_data,
    output reg [3:0] mpr_save_we,
    // Axis values to save, and S-curve and interpolation flags that block speed steps
    input wire [DW-1:0] logical_position_counter,
    input wire [DW-1:0] real_position_counter,
    input wire [DW-1:0] current_timer_value,
    input wire [DW-1:0] current_drive_speed,
    input wire [DW-1:0] current_ramp_value,
    input wire scurve_ramping,
    input wire interp_driving,
    // Parameter loads
    output reg [DW-1:0] load_data,
    output reg ld_drive_speed,
    output reg ld_drive_pulse_count,
    output reg ld_split_pulse_data_one,
    output reg ld_logical_position_counter,
    output reg ld_real_position_counter,
    output reg ld_initial_speed,
    output reg ld_ramp_rate_param,
    // Drive commands
    output reg start_rel,
    output reg start_crel,
    output reg start_abs,
    output reg start_cont_pos,
    output reg start_cont_neg,
    output reg stop_decel,
    output reg stop_instant,
    output reg speed_up,
    output reg speed_down,
    output reg timer_start,
    output reg timer_stop,
    output reg split_start,
    output reg split_stop,
    output reg [3:0] trigger_action_set
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    reg [7:0] pin_s1_r;
    reg [7:0] pin_s2_r;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_r <= 8'h00;
            pin_s2_r <= 8'h00;
        end else begin
            pin_s1_r <= general_io_pin_in;
            pin_s2_r <= pin_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Factor detection per set
    wire [3:0] fire;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : det
            pin_trigger_detect u_det (
                .clk(clk),
                .nrst(nrst),
                .enable(set_enable[g]),
                .factor(set_factor[4*g +: 4]),
                .edge_pin(pin_s2_r[g]),
                .qual_pin(pin_s2_r[g+4]),
                .fire(fire[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Action dispatch
    reg [4:0] act;
    reg [DW-1:0] mpr_word;
    reg [DW-1:0] save_val;
    reg ld_speed_nxt, ld_pcnt_nxt, ld_split_nxt, ld_lpos_nxt, ld_rpos_nxt;
    reg ld_init_nxt, ld_ramp_nxt;
    reg rel_nxt, crel_nxt, abs_nxt, cp_nxt, cn_nxt, sd_nxt, si_nxt;
    reg up_nxt, dn_nxt, tstart_nxt, tstop_nxt, ss_nxt, sp_nxt;
    reg [DW-1:0] load_nxt;
    reg [4*DW-1:0] save_nxt;
    reg [3:0] we_nxt;
    reg [3:0] pulse_go;
    reg save_ok;
    integer k;
    always @* begin
        ld_speed_nxt = 1'b0;
        ld_pcnt_nxt = 1'b0;
        ld_split_nxt = 1'b0;
        ld_lpos_nxt = 1'b0;
        ld_rpos_nxt = 1'b0;
        ld_init_nxt = 1'b0;
        ld_ramp_nxt = 1'b0;
        rel_nxt = 1'b0;
        crel_nxt = 1'b0;
        abs_nxt = 1'b0;
        cp_nxt = 1'b0;
        cn_nxt = 1'b0;
        sd_nxt = 1'b0;
        si_nxt = 1'b0;
        up_nxt = 1'b0;
        dn_nxt = 1'b0;
        tstart_nxt = 1'b0;
        tstop_nxt = 1'b0;
        ss_nxt = 1'b0;
        sp_nxt = 1'b0;
        load_nxt = load_data;
        save_nxt = mpr_save_data;
        we_nxt = 4'h0;
        pulse_go = 4'h0;
        act = 5'h00;
        mpr_word = {DW{1'b0}};
        save_val = {DW{1'b0}};
        save_ok = 1'b0;
        // Lower set wins the shared load bus when sets fire together
        for (k = 3; k >= 0; k = k - 1) begin
            if (fire[k]) begin
                act = set_action[5*k +: 5];
                mpr_word = multi_purpose_compare_register[DW*k +: DW];
                save_ok = 1'b0;
                save_val = {DW{1'b0}};
                case (act)
                    `ACT_LD_SPEED: begin
                        load_nxt = mpr_word;
                        ld_speed_nxt = 1'b1;
                    end
                    `ACT_LD_PCNT: begin
                        load_nxt = mpr_word;
                        ld_pcnt_nxt = 1'b1;
                    end
                    `ACT_LD_SPLIT: begin
                        load_nxt = mpr_word;
                        ld_split_nxt = 1'b1;
                    end
                    `ACT_LD_SET: begin
                        load_nxt = mpr_word;
                        case (k)
                            0: ld_lpos_nxt = 1'b1;
                            1: ld_rpos_nxt = 1'b1;
                            2: ld_init_nxt = 1'b1;
                            default: ld_ramp_nxt = 1'b1;
                        endcase
                    end
                    `ACT_SV_LPOS: begin
                        save_val = logical_position_counter;
                        save_ok = 1'b1;
                    end
                    `ACT_SV_RPOS: begin
                        save_val = real_position_counter;
                        save_ok = 1'b1;
                    end
                    `ACT_SV_TIMER: begin
                        save_val = current_timer_value;
                        save_ok = 1'b1;
                    end
                    `ACT_SV_CUR: begin
                        if (k == 0) begin
                            save_val = current_drive_speed;
                            save_ok = 1'b1;
                        end else if (k == 1) begin
                            save_val = current_ramp_value;
                            save_ok = 1'b1;
                        end
                    end
                    `ACT_PULSE: pulse_go[k] = 1'b1;
                    `ACT_REL: rel_nxt = 1'b1;
                    `ACT_CREL: crel_nxt = 1'b1;
                    `ACT_ABS: abs_nxt = 1'b1;
                    `ACT_CONT_P: cp_nxt = 1'b1;
                    `ACT_CONT_N: cn_nxt = 1'b1;
                    `ACT_MR_REL: begin
                        load_nxt = mpr_word;
                        ld_pcnt_nxt = 1'b1;
                        rel_nxt = 1'b1;
                    end
                    `ACT_MR_ABS: begin
                        load_nxt = mpr_word;
                        ld_pcnt_nxt = 1'b1;
                        abs_nxt = 1'b1;
                    end
                    `ACT_DEC_STOP: sd_nxt = 1'b1;
                    `ACT_INST_STOP: si_nxt = 1'b1;
                    `ACT_SPD_UP: up_nxt = ~(scurve_ramping | interp_driving);
                    `ACT_SPD_DN: dn_nxt = ~(scurve_ramping | interp_driving);
                    `ACT_TMR_START: tstart_nxt = 1'b1;
                    `ACT_TMR_STOP: tstop_nxt = 1'b1;
                    `ACT_SPLIT_START: ss_nxt = 1'b1;
                    `ACT_SPLIT_STOP: sp_nxt = 1'b1;
                    default: ;
                endcase
                if (save_ok) begin
                    save_nxt[DW*k +: DW] = save_val;
                    we_nxt[k] = 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered command outputs
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            load_data <= {DW{1'b0}};
            mpr_save_data <= {4*DW{1'b0}};
            mpr_save_we <= 4'h0;
            ld_drive_speed <= 1'b0;
            ld_drive_pulse_count <= 1'b0;
            ld_split_pulse_data_one <= 1'b0;
            ld_logical_position_counter <= 1'b0;
            ld_real_position_counter <= 1'b0;
            ld_initial_speed <= 1'b0;
            ld_ramp_rate_param <= 1'b0;
            start_rel <= 1'b0;
            start_crel <= 1'b0;
            start_abs <= 1'b0;
            start_cont_pos <= 1'b0;
            start_cont_neg <= 1'b0;
            stop_decel <= 1'b0;
            stop_instant <= 1'b0;
            speed_up <= 1'b0;
            speed_down <= 1'b0;
            timer_start <= 1'b0;
            timer_stop <= 1'b0;
            split_start <= 1'b0;
            split_stop <= 1'b0;
            trigger_action_set <= 4'h0;
        end else begin
            load_data <= load_nxt;
            mpr_save_data <= save_nxt;
            mpr_save_we <= we_nxt;
            ld_drive_speed <= ld_speed_nxt;
            ld_drive_pulse_count <= ld_pcnt_nxt;
            ld_split_pulse_data_one <= ld_split_nxt;
            ld_logical_position_counter <= ld_lpos_nxt;
            ld_real_position_counter <= ld_rpos_nxt;
            ld_initial_speed <= ld_init_nxt;
            ld_ramp_rate_param <= ld_ramp_nxt;
            start_rel <= rel_nxt;
            start_crel <= crel_nxt;
            start_abs <= abs_nxt;
            start_cont_pos <= cp_nxt;
            start_cont_neg <= cn_nxt;
            stop_decel <= sd_nxt;
            stop_instant <= si_nxt;
            speed_up <= up_nxt;
            speed_down <= dn_nxt;
            timer_start <= tstart_nxt;
            timer_stop <= tstop_nxt;
            split_start <= ss_nxt;
            split_stop <= sp_nxt;
            trigger_action_set <= fire;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse output on pins 0-3; retrigger restarts the width
    reg [15:0] pcnt_r [0:3];
    integer j;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (j = 0; j < 4; j = j + 1) begin
                pcnt_r[j] <= 16'h0000;
            end
            general_io_pin_out <= 4'h0;
            general_io_pin_oe <= 4'h0;
        end else begin
            for (j = 0; j < 4; j = j + 1) begin
                if (pulse_go[j]) begin
                    pcnt_r[j] <= PULSE_CYC[15:0];
                    general_io_pin_oe[j] <= 1'b1;
                end else if (pcnt_r[j] != 16'h0000) begin
                    pcnt_r[j] <= pcnt_r[j] - 16'h0001;
                end
                general_io_pin_out[j] <= (pulse_go[j] | (pcnt_r[j] > 16'h0001))
                    ^ pulse_neg_logic[j];
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/sync_action_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sync_action_monitor #(
    parameter DW = 32,
    parameter PULSE_CYC = 3
) (
    // Clock, reset and setup
    input wire clk,
    input wire nrst,
    input wire [3:0] set_enable,
    input wire [15:0] set_factor,
    input wire [19:0] set_action,
    input wire [3:0] pulse_neg_logic,
    // Pins and axis
    input wire [7:0] general_io_pin_in,
    input wire [3:0] general_io_pin_out,
    input wire [3:0] general_io_pin_oe,
    input wire [4*DW-1:0] multi_purpose_compare_register,
    input wire [DW-1:0] logical_position_counter,
    input wire scurve_ramping,
    input wire interp_driving,
    // Results
    input wire [4*DW-1:0] mpr_save_data,
    input wire [3:0] mpr_save_we,
    input wire [DW-1:0] load_data,
    input wire ld_drive_pulse_count,
    input wire start_rel,
    input wire speed_up,
    input wire speed_down,
    input wire [3:0] trigger_action_set
);
default clocking cb @(posedge clk); endclocking
default disable iff (!nrst);
////////////////////////////////////////////////////////////////////////////////
// Active pulse length on pin 0
reg [31:0] pw_r;
wire pw_on = general_io_pin_oe[0] & (general_io_pin_out[0] ^ pulse_neg_logic[0]);
always @(posedge clk or negedge nrst) begin
    if (!nrst) pw_r <= 32'h0000_0000;
    else if (pw_on) pw_r <= pw_r + 32'h0000_0001;
    else pw_r <= 32'h0000_0000;
end
////////////////////////////////////////////////////////////////////////////////
property p_rise_fire;
    set_enable[0] && set_factor[3:0] == 4'hA && $rose(general_io_pin_in[0])
        ##1 set_enable[0] [*2] |=> trigger_action_set[0];
endproperty
a_rise_fire: assert property (p_rise_fire) else $error("set 0 missed rising edge");
property p_edge_cause;
    trigger_action_set[0] |-> $past(general_io_pin_in[0], 3) != $past(general_io_pin_in[0], 4);
endproperty
a_edge_cause: assert property (p_edge_cause) else $error("set 0 fired without edge");
property p_qual_lo;
    trigger_action_set[1] && (set_factor[7:4] == 4'hC || set_factor[7:4] == 4'hE)
        |-> !$past(general_io_pin_in[5], 3);
endproperty
a_qual_lo: assert property (p_qual_lo) else $error("set 1 fired on high qualifier");
property p_qual_hi;
    trigger_action_set[3] && (set_factor[15:12] == 4'hD || set_factor[15:12] == 4'hF)
        |-> $past(general_io_pin_in[7], 3);
endproperty
a_qual_hi: assert property (p_qual_hi) else $error("set 3 fired on low qualifier");
property p_mr_rel;
    trigger_action_set == 4'h1 && set_action[4:0] == 5'h0F |-> start_rel
        && ld_drive_pulse_count && load_data == multi_purpose_compare_register[DW-1:0];
endproperty
a_mr_rel: assert property (p_mr_rel) else $error("register relative start wrong");
property p_save_lp;
    mpr_save_we[2] && set_action[14:10] == 5'h05
        |-> mpr_save_data[2*DW +: DW] == logical_position_counter;
endproperty
a_save_lp: assert property (p_save_lp) else $error("set 2 saved wrong position");
property p_no_save08;
    trigger_action_set[3] && set_action[19:15] == 5'h08 |-> !mpr_save_we[3];
endproperty
a_no_save08: assert property (p_no_save08) else $error("set 3 saved on code 08");
property p_spd_block;
    speed_up || speed_down |-> !scurve_ramping && !interp_driving;
endproperty
a_spd_block: assert property (p_spd_block) else $error("speed step while blocked");
property p_pulse_width;
    $fell(pw_on) |-> pw_r == PULSE_CYC;
endproperty
a_pulse_width: assert property (p_pulse_width) else $error("pin 0 pulse width wrong");
endmodule
`default_nettype wire

// >>> dv/pin_axis_model.sv
`timescale 1ns/1ps
`default_nettype none
module pin_axis_model #(
    parameter DW = 32
) (
    // Far side pins and axis state
    output logic [7:0] pins,
    output logic [DW-1:0] lpos,
    output logic [DW-1:0] rpos,
    output logic [DW-1:0] tmr,
    output logic [DW-1:0] cspd,
    output logic [DW-1:0] cramp,
    output logic scurve,
    output logic interp
);
initial begin
    pins = 8'h00;
    {lpos, rpos, tmr, cspd, cramp} = '0;
    {scurve, interp} = 2'b00;
end
// Edge on pin k, qualifier on pin k+4
task automatic put_pins(input logic [7:0] v);
    pins <= v;
endtask
task automatic set_axis(input bit blk);
    bit which;
    which = $urandom % 2;
    lpos <= $urandom;
    rpos <= $urandom;
    tmr <= $urandom;
    cspd <= $urandom;
    cramp <= $urandom;
    scurve <= blk && which;
    interp <= blk && !which;
endtask
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
localparam DW = 32;
logic clk, nrst;
logic [3:0] set_enable, pulse_neg_logic;
logic [15:0] set_factor;
logic [19:0] set_action;
logic [4*DW-1:0] mpr;
wire [7:0] pins;
wire [DW-1:0] lpos, rpos, tmr, cspd, cramp, load_data;
wire scurve, interp;
wire [3:0] pin_out, pin_oe, save_we, trig;
wire [4*DW-1:0] save_data;
wire [19:0] stb;
int mismatches, checks;
logic [3:0] facs [7] = '{4'h0, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
pin_axis_model #(.DW(DW)) far (.pins(pins), .lpos(lpos), .rpos(rpos), .tmr(tmr),
    .cspd(cspd), .cramp(cramp), .scurve(scurve), .interp(interp));
sync_action_trigger_dispatch #(.DW(DW), .PULSE_CYC(3)) uut (.clk(clk), .nrst(nrst),
    .set_enable(set_enable), .set_factor(set_factor), .set_action(set_action),
    .pulse_neg_logic(pulse_neg_logic), .general_io_pin_in(pins),
    .general_io_pin_out(pin_out), .general_io_pin_oe(pin_oe),
    .multi_purpose_compare_register(mpr), .mpr_save_data(save_data), .mpr_save_we(save_we),
    .logical_position_counter(lpos), .real_position_counter(rpos),
    .current_timer_value(tmr), .current_drive_speed(cspd), .current_ramp_value(cramp),
    .scurve_ramping(scurve), .interp_driving(interp), .load_data(load_data),
    .ld_drive_speed(stb[0]), .ld_drive_pulse_count(stb[1]), .ld_split_pulse_data_one(stb[2]),
    .ld_logical_position_counter(stb[3]), .ld_real_position_counter(stb[4]),
    .ld_initial_speed(stb[5]), .ld_ramp_rate_param(stb[6]), .start_rel(stb[7]),
    .start_crel(stb[8]), .start_abs(stb[9]), .start_cont_pos(stb[10]),
    .start_cont_neg(stb[11]), .stop_decel(stb[12]), .stop_instant(stb[13]),
    .speed_up(stb[14]), .speed_down(stb[15]), .timer_start(stb[16]), .timer_stop(stb[17]),
    .split_start(stb[18]), .split_stop(stb[19]), .trigger_action_set(trig));
initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
end
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
        $display("FAIL %s expected %h seen %h", nm, exp, got);
        mismatches++;
    end
endtask
task automatic cyc(input int n);
    repeat (n) @(posedge clk);
endtask
task automatic report_and_stop();
    if (mismatches == 0 && checks > 0) begin
        $display("Finished cleanly");
    end else begin
        $display("Finished with errors");
    end
    $finish;
endtask
function automatic logic [19:0] exp_stb(input int c, input int k, input bit blk);
    if (c >= 1 && c <= 3) return 20'h0_0001 << (c - 1);
    if (c == 4) return 20'h0_0008 << k;
    if (c >= 10 && c <= 14) return 20'h0_0001 << (c - 3);
    if (c == 15) return 20'h0_0082;
    if (c == 16) return 20'h0_0202;
    if ((c == 19 || c == 20) && blk) return 20'h0_0000;
    if (c >= 17 && c <= 24) return 20'h0_0001 << (c - 5);
    return 20'h0_0000;
endfunction
// Which sets a pin step from p to n should trigger
function automatic logic [3:0] fires(input logic [15:0] f, input logic [7:0] p,
    input logic [7:0] n);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 0; k < 4; k++) begin
        case (f[4*k +: 4])
            4'hA: r[k] = !p[k] && n[k];
            4'hB: r[k] = p[k] && !n[k];
            4'hC: r[k] = !p[k] && n[k] && !n[k+4];
            4'hD: r[k] = !p[k] && n[k] && n[k+4];
            4'hE: r[k] = p[k] && !n[k] && !n[k+4];
            4'hF: r[k] = p[k] && !n[k] && n[k+4];
            default: r[k] = 1'b0;
        endcase
    end
    return r;
endfunction
////////////////////////////////////////////////////////////////////////////////
initial begin
    cyc(20000);
    mismatches++;
    report_and_stop();
end
initial begin
    logic [19:0] es;
    logic [7:0] pv, nv;
    logic [DW-1:0] ed;
    logic [3:0] ew;
    void'($urandom(89457));
    {nrst, set_enable, set_factor, set_action, mpr} = '0;
    pulse_neg_logic = 4'($urandom);
    mismatches = 0;
    checks = 0;
    cyc(4);
    nrst <= 1'b1;
    for (int c = 0; c <= 24; c++) begin
        for (int k = 0; k < 4; k++) begin
            cyc(1);
            far.set_axis(bit'($urandom % 2));
            mpr <= {$urandom, $urandom, $urandom, $urandom};
            set_action <= 20'(c << (5 * k));
            set_factor <= 16'hAAAA;
            set_enable <= 4'h1 << k;
            far.put_pins(8'h00);
            cyc(4);
            far.put_pins(8'h01 << k);
            cyc(3);
            #1;
            es = exp_stb(c, k, scurve || interp);
            ed = c == 5 ? lpos : c == 6 ? rpos : c == 7 ? tmr : k == 0 ? cspd : cramp;
            ew = (c >= 5 && c <= 7) || (c == 8 && k < 2) ? 4'h1 << k : 4'h0;
            chk("trigger", trig, 4'h1 << k);
            chk("strobes", stb, es);
            chk("save_we", save_we, ew);
            if (ew != 0) chk("save_data", save_data[k*DW +: DW], ed);
            if (es[6:0] != 0) chk("load_data", load_data, mpr[k*DW +: DW]);
            if (c == 9) begin
                chk("pin_pulse", {pin_oe[k], pin_out[k]}, {1'b1, ~pulse_neg_logic[k]});
            end
            cyc(5);
            #1;
            if (c == 9) begin
                chk("pin_idle", {pin_oe[k], pin_out[k]}, {1'b1, pulse_neg_logic[k]});
            end
        end
    end
    set_action <= 20'h0_0000;
    for (int r = 0; r < 40; r++) begin
        cyc(1);
        set_enable <= 4'h0;
        // NOP factor sits among the choices for sets driven by others
        set_factor <= {facs[$urandom % 7], facs[$urandom % 7], facs[$urandom % 7],
            facs[$urandom % 7]};
        pv = 8'($urandom);
        far.put_pins(pv);
        cyc(4);
        set_enable <= 4'hF;
        cyc(2);
        #1;
        chk("trigger", trig, 4'h0);
        cyc(2);
        for (int s = 0; s < 12; s++) begin
            nv = 8'($urandom);
            far.put_pins(nv);
            cyc(3);
            #1;
            chk("trigger", trig, fires(set_factor, pv, nv));
            pv = nv;
            cyc(1);
        end
    end
    report_and_stop();
end
endmodule
bind sync_action_trigger_dispatch sync_action_monitor #(.DW(DW), .PULSE_CYC(PULSE_CYC)) mon (
    .clk, .nrst, .set_enable, .set_factor, .set_action, .pulse_neg_logic,
    .general_io_pin_in, .general_io_pin_out, .general_io_pin_oe,
    .multi_purpose_compare_register, .logical_position_counter, .scurve_ramping,
    .interp_driving, .mpr_save_data, .mpr_save_we, .load_data, .ld_drive_pulse_count,
    .start_rel, .speed_up, .speed_down, .trigger_action_set);
`default_nettype wire
